// *** rtl/mig_exec.v ***
// Execution of the move instruction group: flags, enable masks, segment RAM, pulse generator.
`timescale 1ns/10ps
`include "mig_exec_consts.vh"
module mig_exec #(
	parameter SEG_ENTRIES = 32,
	parameter SEG_ADDR_W  = 5,
	parameter DATA_W      = 4
) (
	input  wire                          core_clk,
	input  wire                          rst,
	input  wire                          instrValid,
	input  wire [15:0]                   instrWord,
	input  wire [DATA_W-1:0]             dataRamRdData,
	input  wire [DATA_W-1:0]             workRegRdData,
	input  wire                          div0Overflow,
	input  wire                          timer0Underflow,
	input  wire                          wakeInputChange,
	input  wire                          div1Overflow,
	input  wire                          timer1Underflow,
	input  wire [3:0]                    timerOneModeReg,
	input  wire                          timer1Freq,
	output reg  [DATA_W-1:0]             workingTotalReg,
	output reg                           zeroFlag,
	output reg                           carryFlag,
	output reg  [7:0]                    holdReleaseEnables,
	output reg  [7:0]                    interruptAcceptEnables,
	output reg  [7:0]                    segmentPinDriveType,
	output reg  [7:0]                    pulseGeneratorSetting,
	output reg  [SEG_ENTRIES*DATA_W-1:0] segmentDataRam,
	output reg                           holdReleaseReq,
	output reg  [7:0]                    interruptAccepted,
	output reg                           pulseOutputPin
);

	// Instruction decode.
	// Decodes compare only the opcode bits, except the accumulator segment form, which also needs a zero low nibble.
	wire                  isLoadAcc;
	wire                  isLoadCarry;
	wire                  isHoldMask;
	wire                  isIntMask;
	wire                  isDriveType;
	wire                  isPulseGen;
	wire                  isSegFromAcc;
	wire                  isSegFromWork;
	wire                  isSegFromImm;
	wire [SEG_ADDR_W-1:0] segAddr;
	wire [7:0]            imm8;
	wire [DATA_W-1:0]     imm4;

	assign isLoadAcc = instrValid &&
		(instrWord[`MIG_OP_LDACC_MSB:`MIG_OP_LDACC_LSB] == `MIG_OP_LDACC);
	assign isLoadCarry = instrValid &&
		(instrWord[`MIG_OP_LDCF_MSB:`MIG_OP_LDCF_LSB] == `MIG_OP_LDCF);
	assign isHoldMask = instrValid &&
		(instrWord[`MIG_OP_BYTE_MSB:`MIG_OP_BYTE_LSB] == `MIG_OP_HEF);
	assign isIntMask = instrValid &&
		(instrWord[`MIG_OP_BYTE_MSB:`MIG_OP_BYTE_LSB] == `MIG_OP_IEF);
	assign isDriveType = instrValid &&
		(instrWord[`MIG_OP_BYTE_MSB:`MIG_OP_BYTE_LSB] == `MIG_OP_DRV);
	assign isPulseGen = instrValid &&
		(instrWord[`MIG_OP_BYTE_MSB:`MIG_OP_BYTE_LSB] == `MIG_OP_PGEN);
	// The accumulator form carries four zero bits in its low nibble.
	assign isSegFromAcc = instrValid &&
		(instrWord[`MIG_OP_SEG_MSB:`MIG_OP_SEG_LSB] == `MIG_OP_SEGACC) &&
		(instrWord[`MIG_NIB_MSB:`MIG_NIB_LSB] == `MIG_SEGACC_ZERO);
	assign isSegFromWork = instrValid &&
		(instrWord[`MIG_OP_SEG_MSB:`MIG_OP_SEG_LSB] == `MIG_OP_SEGWR);
	assign isSegFromImm = instrValid &&
		(instrWord[`MIG_OP_SEG_MSB:`MIG_OP_SEG_LSB] == `MIG_OP_SEGIMM);

	assign segAddr = instrWord[`MIG_SEGADDR_MSB:`MIG_SEGADDR_LSB];
	assign imm8    = instrWord[`MIG_IMM8_MSB:`MIG_IMM8_LSB];
	assign imm4    = instrWord[`MIG_NIB_MSB:`MIG_NIB_LSB];

	// Working total register.
	always @(posedge core_clk) begin
		if (rst) begin
			workingTotalReg <= `MIG_RST_NIB;
		end else if (isLoadAcc) begin
			workingTotalReg <= dataRamRdData;
		end
	end

	// Zero flag follows the loaded word, so it agrees with the total after reset too.
	always @(posedge core_clk) begin
		if (rst) begin
			zeroFlag <= 1'b1;
		end else if (isLoadAcc) begin
			zeroFlag <= (dataRamRdData == {DATA_W{1'b0}});
		end
	end

	// Carry flag; no other flag moves with it.
	always @(posedge core_clk) begin
		if (rst) begin
			carryFlag <= 1'b0;
		end else if (isLoadCarry) begin
			carryFlag <= dataRamRdData[0];
		end
	end

	// Hold-release mask; reserved positions are held at zero.
	always @(posedge core_clk) begin
		if (rst) begin
			holdReleaseEnables <= `MIG_RST_BYTE;
		end else if (isHoldMask) begin
			holdReleaseEnables <= imm8 & `MIG_ENABLE_MASK;
		end
	end

	// Interrupt-accept mask; reserved positions are held at zero.
	always @(posedge core_clk) begin
		if (rst) begin
			interruptAcceptEnables <= `MIG_RST_BYTE;
		end else if (isIntMask) begin
			interruptAcceptEnables <= imm8 & `MIG_ENABLE_MASK;
		end
	end

	// Event vector laid out on the enable bit positions.
	wire [7:0] eventVec;

	// Laying events on the mask positions lets each mask gate its event with one AND per bit.
	assign eventVec[`MIG_EV_DIV0] = div0Overflow;
	assign eventVec[`MIG_EV_TMR0] = timer0Underflow;
	assign eventVec[`MIG_EV_WAKE] = wakeInputChange;
	assign eventVec[3]            = 1'b0;
	assign eventVec[`MIG_EV_DIV1] = div1Overflow;
	assign eventVec[5]            = 1'b0;
	assign eventVec[6]            = 1'b0;
	assign eventVec[`MIG_EV_TMR1] = timer1Underflow;

	wire [7:0] holdWake;
	wire [7:0] intTake;

	assign holdWake[`MIG_EV_DIV0] = eventVec[`MIG_EV_DIV0] & holdReleaseEnables[`MIG_EV_DIV0];
	assign holdWake[`MIG_EV_TMR0] = eventVec[`MIG_EV_TMR0] & holdReleaseEnables[`MIG_EV_TMR0];
	assign holdWake[`MIG_EV_WAKE] = eventVec[`MIG_EV_WAKE] & holdReleaseEnables[`MIG_EV_WAKE];
	assign holdWake[`MIG_EV_DIV1] = eventVec[`MIG_EV_DIV1] & holdReleaseEnables[`MIG_EV_DIV1];
	assign holdWake[`MIG_EV_TMR1] = eventVec[`MIG_EV_TMR1] & holdReleaseEnables[`MIG_EV_TMR1];
	// Reserved positions never gate an event.
	assign holdWake[3] = 1'b0;
	assign holdWake[5] = 1'b0;
	assign holdWake[6] = 1'b0;

	assign intTake[`MIG_EV_DIV0] = eventVec[`MIG_EV_DIV0] & interruptAcceptEnables[`MIG_EV_DIV0];
	assign intTake[`MIG_EV_TMR0] = eventVec[`MIG_EV_TMR0] & interruptAcceptEnables[`MIG_EV_TMR0];
	assign intTake[`MIG_EV_WAKE] = eventVec[`MIG_EV_WAKE] & interruptAcceptEnables[`MIG_EV_WAKE];
	assign intTake[`MIG_EV_DIV1] = eventVec[`MIG_EV_DIV1] & interruptAcceptEnables[`MIG_EV_DIV1];
	assign intTake[`MIG_EV_TMR1] = eventVec[`MIG_EV_TMR1] & interruptAcceptEnables[`MIG_EV_TMR1];
	// Reserved positions never raise an interrupt.
	assign intTake[3] = 1'b0;
	assign intTake[5] = 1'b0;
	assign intTake[6] = 1'b0;

	// Gated events leave one cycle after their cause.
	always @(posedge core_clk) begin
		if (rst) begin
			holdReleaseReq <= 1'b0;
		end else begin
			holdReleaseReq <= |holdWake;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			interruptAccepted <= `MIG_RST_BYTE;
		end else begin
			interruptAccepted <= intTake;
		end
	end

	// Segment pin drive type.
	always @(posedge core_clk) begin
		if (rst) begin
			segmentPinDriveType <= `MIG_RST_BYTE;
		end else if (isDriveType) begin
			segmentPinDriveType <= imm8;
		end
	end

	// Segment data RAM: one write port fed from three sources.
	reg [DATA_W-1:0] segWrData;
	reg              segWrEn;

	// Only one source decodes per word, so the order of the tests sets no priority.
	always @* begin
		segWrEn   = 1'b0;
		segWrData = {DATA_W{1'b0}};
		if (isSegFromAcc) begin
			segWrEn   = 1'b1;
			segWrData = workingTotalReg;
		end
		if (isSegFromWork) begin
			segWrEn   = 1'b1;
			segWrData = workRegRdData;
		end
		if (isSegFromImm) begin
			segWrEn   = 1'b1;
			segWrData = imm4;
		end
	end

	// The write lands at the clock edge that takes the instruction.
	always @(posedge core_clk) begin
		if (rst) begin
			segmentDataRam <= {(SEG_ENTRIES*DATA_W){1'b0}};
		end else if (segWrEn) begin
			segmentDataRam[segAddr*DATA_W +: DATA_W] <= segWrData;
		end
	end

	// Pulse generator setting.
	always @(posedge core_clk) begin
		if (rst) begin
			pulseGeneratorSetting <= `MIG_RST_BYTE;
		end else if (isPulseGen) begin
			pulseGeneratorSetting <= imm8;
		end
	end

	// Frequency taps of the system clock.
	// The divider runs from reset and is never stopped, so the taps keep a fixed phase.
	wire [`MIG_DIV_W-1:0] divCount;

	mig_freq_div #(
		.WIDTH (`MIG_DIV_W)
	) u_div (
		.core_clk (core_clk),
		.rst      (rst),
		.count    (divCount)
	);

	wire [5:0] lowRate;
	wire [5:0] lowSel;
	wire       lowGate;
	wire [1:0] carSel;
	reg        carrier;
	reg        next_pulseOutputPin;

	assign lowRate[0] = divCount[`MIG_TAP_256];
	assign lowRate[1] = divCount[`MIG_TAP_512];
	assign lowRate[2] = divCount[`MIG_TAP_4096];
	assign lowRate[3] = divCount[`MIG_TAP_8192];
	assign lowRate[4] = divCount[`MIG_TAP_16384];
	assign lowRate[5] = divCount[`MIG_TAP_32768];
	assign lowSel  = pulseGeneratorSetting[`MIG_GEN_LOW_MSB:`MIG_GEN_LOW_LSB];
	// Combined low-rate gate
	// An unselected bit forces its term high, so no selection leaves the carrier ungated.
	assign lowGate = &(lowRate | ~lowSel);
	assign carSel  = pulseGeneratorSetting[`MIG_GEN_CAR_MSB:`MIG_GEN_CAR_LSB];

	always @* begin
		case (carSel)
			`MIG_CAR_LOW:   carrier = 1'b0;
			`MIG_CAR_HIGH:  carrier = 1'b1;
			`MIG_CAR_DIV16: carrier = divCount[`MIG_TAP_16];
			`MIG_CAR_DIV8:  carrier = divCount[`MIG_TAP_8];
			default:        carrier = 1'b0;
		endcase
	end

	always @* begin
		if (timerOneModeReg[`MIG_MODE_PIN_SEL]) begin
			next_pulseOutputPin = timer1Freq;
		end else begin
			next_pulseOutputPin = carrier & lowGate;
		end
	end

	// Waveform to pin
	// Registering the pin keeps it free of glitches when the source switches.
	always @(posedge core_clk) begin
		if (rst) begin
			pulseOutputPin <= 1'b0;
		end else begin
			pulseOutputPin <= next_pulseOutputPin;
		end
	end

endmodule

// *** rtl/mig_exec_consts.vh ***
// Constants for the move instruction group execution block.
`ifndef MIG_EXEC_CONSTS_VH
`define MIG_EXEC_CONSTS_VH

`define MIG_CLK_HZ          25000000
`define MIG_CLK_PERIOD_NS   40

// Opcode fields: the upper bits of the word compared against a fixed value.
`define MIG_OP_LDACC_MSB    15
`define MIG_OP_LDACC_LSB    7
`define MIG_OP_LDACC        9'h09d
`define MIG_OP_LDCF_MSB     15
`define MIG_OP_LDCF_LSB     7
`define MIG_OP_LDCF         9'h0b0
`define MIG_OP_HEF          8'h43
`define MIG_OP_IEF          8'h51
`define MIG_OP_DRV          8'h0f
`define MIG_OP_PGEN         8'h12
`define MIG_OP_BYTE_MSB     15
`define MIG_OP_BYTE_LSB     8
`define MIG_OP_SEGACC       7'h03
`define MIG_OP_SEGIMM       7'h02
`define MIG_OP_SEGWR        7'h22
`define MIG_OP_SEG_MSB      15
`define MIG_OP_SEG_LSB      9
`define MIG_SEGACC_ZERO     4'h0

// Operand fields.
`define MIG_RADDR_MSB       6
`define MIG_RADDR_LSB       0
`define MIG_IMM8_MSB        7
`define MIG_IMM8_LSB        0
`define MIG_SEGADDR_MSB     8
`define MIG_SEGADDR_LSB     4
`define MIG_NIB_MSB         3
`define MIG_NIB_LSB         0

// Event and enable bit positions.
`define MIG_EV_DIV0         0
`define MIG_EV_TMR0         1
`define MIG_EV_WAKE         2
`define MIG_EV_DIV1         4
`define MIG_EV_TMR1         7
`define MIG_ENABLE_MASK     8'h97

// Reset values.
`define MIG_RST_BYTE        8'h00
`define MIG_RST_NIB         4'h0

// Timer 1 mode bit that hands the pulse pin to timer 1.
`define MIG_MODE_PIN_SEL    2

// Divider taps: Fosc/2^n is bit n-1 of a free-running counter.
`define MIG_DIV_W           15
`define MIG_TAP_256         7
`define MIG_TAP_512         8
`define MIG_TAP_4096        11
`define MIG_TAP_8192        12
`define MIG_TAP_16384       13
`define MIG_TAP_32768       14
`define MIG_TAP_16          3
`define MIG_TAP_8           2

// Generator setting fields and carrier codes.
`define MIG_GEN_LOW_MSB     5
`define MIG_GEN_LOW_LSB     0
`define MIG_GEN_CAR_MSB     7
`define MIG_GEN_CAR_LSB     6
`define MIG_CAR_LOW         2'h0
`define MIG_CAR_HIGH        2'h1
`define MIG_CAR_DIV16       2'h2
`define MIG_CAR_DIV8        2'h3

`endif

// *** rtl/mig_freq_div.v ***
// Free-running binary divider of the system clock.
`timescale 1ns/10ps
module mig_freq_div #(
	parameter WIDTH = 15
) (
	input  wire             core_clk,
	input  wire             rst,
	output reg  [WIDTH-1:0] count
);

	always @(posedge core_clk) begin
		if (rst) begin
			count <= {WIDTH{1'b0}};
		end else begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule

// *** tb/mig_exec_properties.sv ***
// Checker for the move instruction group execution block.
`timescale 1ns/10ps
module mig_exec_properties #(
	parameter SEG_ENTRIES = 32,
	parameter DATA_W      = 4
) (
	input wire logic                          core_clk,
	input wire logic                          rst,
	input wire logic                          instrValid,
	input wire logic [15:0]                   instrWord,
	input wire logic [DATA_W-1:0]             dataRamRdData,
	input wire logic [DATA_W-1:0]             workRegRdData,
	input wire logic                          div0Overflow,
	input wire logic                          timer0Underflow,
	input wire logic                          wakeInputChange,
	input wire logic                          div1Overflow,
	input wire logic                          timer1Underflow,
	input wire logic [3:0]                    timerOneModeReg,
	input wire logic                          timer1Freq,
	input wire logic [DATA_W-1:0]             workingTotalReg,
	input wire logic                          zeroFlag,
	input wire logic                          carryFlag,
	input wire logic [7:0]                    holdReleaseEnables,
	input wire logic [7:0]                    interruptAcceptEnables,
	input wire logic [7:0]                    pulseGeneratorSetting,
	input wire logic [SEG_ENTRIES*DATA_W-1:0] segmentDataRam,
	input wire logic                          holdReleaseReq,
	input wire logic [7:0]                    interruptAccepted,
	input wire logic                          pulseOutputPin
);
	wire [7:0] ev = {timer1Underflow, 2'b00, div1Overflow, 1'b0, wakeInputChange,
		timer0Underflow, div0Overflow};
	reg              segWr;
	reg [4:0]        segAddr;
	reg [DATA_W-1:0] segVal;
	always @(posedge core_clk) begin
		segWr <= !rst && instrValid && (instrWord[15:9] == 7'h02 || instrWord[15:9] == 7'h22
			|| (instrWord[15:9] == 7'h03 && instrWord[3:0] == 4'h0));
		segAddr <= instrWord[8:4];
		segVal <= instrWord[15:9] == 7'h02 ? instrWord[3:0] :
			instrWord[15:9] == 7'h22 ? workRegRdData : workingTotalReg;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence sLoad;
		instrValid && instrWord[15:7] == 9'h09d;
	endsequence
	sequence sCarry;
		instrValid && instrWord[15:7] == 9'h0b0;
	endsequence
	AST_LOAD_TOTAL: assert property (sLoad |=> workingTotalReg == $past(dataRamRdData)
		&& zeroFlag == ($past(dataRamRdData) == 4'h0)) else $error("load total wrong");
	AST_LOAD_CARRY: assert property (sCarry |=> carryFlag == $past(dataRamRdData[0])
		&& $stable(zeroFlag)) else $error("carry load wrong");
	AST_HOLD_MASK: assert property (instrValid && instrWord[15:8] == 8'h43
		|=> holdReleaseEnables == ($past(instrWord[7:0]) & 8'h97)) else $error("hold mask");
	AST_HOLD_WAKE: assert property (1 |=> holdReleaseReq ==
		|($past(ev) & $past(holdReleaseEnables))) else $error("hold release wrong");
	AST_INT_MASK: assert property (instrValid && instrWord[15:8] == 8'h51
		|=> interruptAcceptEnables == ($past(instrWord[7:0]) & 8'h97)) else $error("int mask");
	AST_INT_ACCEPT: assert property (1 |=> interruptAccepted ==
		($past(ev) & $past(interruptAcceptEnables))) else $error("interrupt accept wrong");
	AST_SEG_WRITE: assert property (segWr |->
		segmentDataRam[segAddr*DATA_W +: DATA_W] == segVal) else $error("segment write");
	AST_GEN_SETTING: assert property (instrValid && instrWord[15:8] == 8'h12
		|=> pulseGeneratorSetting == $past(instrWord[7:0])) else $error("generator setting");
	AST_PIN_TIMER: assert property (timerOneModeReg[2]
		|=> pulseOutputPin == $past(timer1Freq)) else $error("pin source wrong");
endmodule
bind mig_exec mig_exec_properties #(.SEG_ENTRIES(SEG_ENTRIES), .DATA_W(DATA_W)) chk (.*);

// *** tb/mig_exec_tb.sv ***
// Self-checking bench for the move instruction group execution block.
`timescale 1ns/10ps
module mig_exec_tb;
	logic         core_clk = 0, rst = 1, instrValid = 0, timer1Freq = 0;
	logic [15:0]  instrWord = 16'h0000;
	logic [7:0]   ev = 8'h00;
	logic [3:0]   timerOneModeReg = 4'h0;
	wire  [3:0]   dataRamRdData, workRegRdData, workingTotalReg;
	wire          zeroFlag, carryFlag, holdReleaseReq, pulseOutputPin;
	wire  [7:0]   holdReleaseEnables, interruptAcceptEnables, segmentPinDriveType;
	wire  [7:0]   pulseGeneratorSetting, interruptAccepted;
	wire  [127:0] segRam;
	int           nMismatch = 0, checksDone = 0, cycles = 0, cnt, i;
	int           evBit[5] = '{0, 1, 2, 4, 7};
	mig_exec dut (.core_clk(core_clk), .rst(rst), .instrValid(instrValid),
		.instrWord(instrWord), .dataRamRdData(dataRamRdData), .workRegRdData(workRegRdData),
		.div0Overflow(ev[0]), .timer0Underflow(ev[1]), .wakeInputChange(ev[2]),
		.div1Overflow(ev[4]), .timer1Underflow(ev[7]), .timerOneModeReg(timerOneModeReg),
		.timer1Freq(timer1Freq), .workingTotalReg(workingTotalReg), .zeroFlag(zeroFlag),
		.carryFlag(carryFlag), .holdReleaseEnables(holdReleaseEnables),
		.interruptAcceptEnables(interruptAcceptEnables),
		.segmentPinDriveType(segmentPinDriveType),
		.pulseGeneratorSetting(pulseGeneratorSetting), .segmentDataRam(segRam),
		.holdReleaseReq(holdReleaseReq), .interruptAccepted(interruptAccepted),
		.pulseOutputPin(pulseOutputPin));
	mig_mem_model mem (.instrWord(instrWord), .dataRamRdData(dataRamRdData),
		.workRegRdData(workRegRdData));
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			nMismatch++;
			testDone();
		end
	end
	task automatic testDone();
		if (nMismatch == 0 && checksDone > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			nMismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic exec(logic [15:0] w);
		@(posedge core_clk);
		#1 instrValid = 1;
		instrWord = w;
		@(posedge core_clk);
		#1 instrValid = 0;
	endtask
	task automatic pulse(int b);
		@(posedge core_clk);
		#1 ev[b] = 1;
		@(posedge core_clk);
		#1 ev[b] = 0;
	endtask
	// Counts high cycles of the pin over a window that spans whole periods.
	task automatic countPin(logic [7:0] s, int exp);
		exec({8'h12, s});
		check("setting", s, pulseGeneratorSetting);
		repeat (4) @(posedge core_clk);
		cnt = 0;
		repeat (512) begin
			@(posedge core_clk);
			#1 cnt += pulseOutputPin;
		end
		check("pin", exp, cnt);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		#1 rst = 0;
		exec(16'h4e85);
		check("total", 4'h0, workingTotalReg);
		check("zero", 1'b1, zeroFlag);
		exec(16'h4e8a);
		check("total", 4'hf, workingTotalReg);
		check("zero", 1'b0, zeroFlag);
		exec(16'h580a);
		check("carry", 1'b1, carryFlag);
		exec(16'h5805);
		check("carry", 1'b0, carryFlag);
		check("total", 4'hf, workingTotalReg);
		exec(16'h43ff);
		check("hold mask", 8'h97, holdReleaseEnables);
		exec(16'h51ff);
		check("int mask", 8'h97, interruptAcceptEnables);
		for (i = 0; i < 5; i++) begin
			pulse(evBit[i]);
			check("hold req", 1'b1, holdReleaseReq);
			check("accepted", 8'h01 << evBit[i], interruptAccepted);
		end
		exec(16'h4368);
		exec(16'h5100);
		check("hold mask", 8'h00, holdReleaseEnables);
		pulse(7);
		check("hold req", 1'b0, holdReleaseReq);
		check("accepted", 8'h00, interruptAccepted);
		exec(16'h0fa5);
		check("drive type", 8'ha5, segmentPinDriveType);
		exec(16'h05f9);
		exec(16'h0406);
		exec(16'h4413);
		exec(16'h0620);
		check("seg31", 4'h9, segRam[124 +: 4]);
		check("seg0", 4'h6, segRam[0 +: 4]);
		check("seg1", 4'hc, segRam[4 +: 4]);
		check("seg2", 4'hf, segRam[8 +: 4]);
		check("seg30", 4'h0, segRam[120 +: 4]);
		countPin(8'h00, 0);
		countPin(8'h40, 512);
		countPin(8'h80, 256);
		countPin(8'hc0, 256);
		countPin(8'h41, 256);
		countPin(8'h43, 128);
		timerOneModeReg = 4'h4;
		timer1Freq = 1;
		countPin(8'h00, 512);
		testDone();
	end
endmodule

// *** tb/mig_mem_model.sv ***
// Data memory and working register model feeding the execution block.
`timescale 1ns/10ps
module mig_mem_model (
	input  wire logic [15:0] instrWord,
	output wire logic [3:0]  dataRamRdData,
	output wire logic [3:0]  workRegRdData
);
	// Each location reads a value derived from its address.
	assign dataRamRdData = instrWord[3:0] ^ 4'h5;
	assign workRegRdData = ~instrWord[3:0];
endmodule
